// ===== svsq_top.sv
// Servo amplifier power and servo sequencer with status LED and APB registers.
`include "svsq_map.svh"
module svsq_top #(
    parameter int CYCLES_PER_MS = `SVSQ_MS_NS / `SVSQ_CLK_NS
) (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // APB slave.
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Host and amplifier pins.
    input wire logic MAIN_POWER_OK_I,
    input wire logic POWER_ENABLE_I,
    input wire logic SERVO_ON_I,
    input wire logic ALARM_I,
    input wire logic [6:0] WARNING_I,
    // Sequencer outputs.
    output logic AMP_READY_O,
    output logic POWER_ON_O,
    output logic SETUP_COMPLETE_O,
    output logic OPERATION_SETUP_COMPLETE_SECOND_O,
    output logic DYN_BRAKE_O,
    output logic HOLD_BRAKE_RELEASE_O,
    output logic CMD_PERMIT_O,
    output logic MOTOR_EXCITE_O,
    // Status display and interrupt.
    output logic FRONT_STATUS_LED_O,
    output logic [3:0] STATUS_CODE_O,
    output logic IRQ_O
);
    svsq_tick_if tk ();
    svsq_tick #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .tb(tk)
    );

    // Output levels for each sequencer state.
    function automatic svsq_pkg::svsq_outs_t outs_of(svsq_pkg::svsq_state_t s, logic db_ok);
        svsq_pkg::svsq_outs_t o;
        o = '0;
        o.power_on = (s >= svsq_pkg::ST_POWERED);
        o.setup_first = (s >= svsq_pkg::ST_SETUP);
        o.setup_second = (s >= svsq_pkg::ST_DB_WAIT);
        o.motor_excite = (s >= svsq_pkg::ST_RELEASE);
        o.hold_release = (s == svsq_pkg::ST_RUN);
        o.cmd_permit = (s == svsq_pkg::ST_RUN);
        o.dyn_brake = db_ok && (s < svsq_pkg::ST_RELEASE);
        return o;
    endfunction

    // Three-stage pin synchronisers; a change counts once stages two and three agree.
    logic [10:0] s1_reg, s2_reg, s3_reg, pin_reg;
    wire logic [10:0] pin_raw = {ALARM_I, WARNING_I, SERVO_ON_I, POWER_ENABLE_I,
        MAIN_POWER_OK_I};
    wire logic [10:0] agree = ~(s2_reg ^ s3_reg);
    wire logic [10:0] pin_next = (s2_reg & agree) | (pin_reg & ~agree);
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            s1_reg <= 11'h000;
            s2_reg <= 11'h000;
            s3_reg <= 11'h000;
            pin_reg <= 11'h000;
        end
        else
        begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= pin_next;
        end
    end
    wire logic main_ok = pin_reg[0];
    wire logic pwr_en = pin_reg[1];
    wire logic servo_on = pin_reg[2];
    wire logic warn_any = |pin_reg[9:3];
    wire logic alarm = pin_reg[10];
    wire logic power_good = main_ok && pwr_en;

    // Sequencer state, delay counter and registers.
    svsq_pkg::svsq_state_t state_reg, state_next;
    svsq_pkg::svsq_outs_t outs_reg;
    logic [8:0] dly_reg;
    logic ctrl_db_reg, alarm_d_reg, led_reg, ready_reg;
    logic [3:0] code_reg, irq_stat_reg, irq_mask_reg;
    logic [31:0] prdata_reg;
    wire logic [8:0] rel_ms = 9'(`SVSQ_BRK_REL_MS + `SVSQ_BRK_EXTRA_MS);
    wire logic tick = tk.ms_tick;
    wire logic at_pwr = tick && (dly_reg == `SVSQ_PWR_ON_MS);
    wire logic at_db = tick && (dly_reg == `SVSQ_DB_WAIT_MS);
    wire logic at_rel = tick && (dly_reg == rel_ms);
    wire logic at_eng = tick && (dly_reg == `SVSQ_BRK_ENG_MS);

    // Next-state logic: delays end on the tick after the count reaches its target.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            svsq_pkg::ST_IDLE: if (power_good) state_next = svsq_pkg::ST_PWR_WAIT;
            svsq_pkg::ST_PWR_WAIT: if (at_pwr) state_next = svsq_pkg::ST_POWERED;
            svsq_pkg::ST_POWERED: if (tick) state_next = svsq_pkg::ST_SETUP;
            svsq_pkg::ST_SETUP: if (tick) state_next = svsq_pkg::ST_DB_WAIT;
            svsq_pkg::ST_DB_WAIT: if (at_db) state_next = svsq_pkg::ST_STANDBY;
            svsq_pkg::ST_STANDBY: if (servo_on) state_next = svsq_pkg::ST_RELEASE;
            svsq_pkg::ST_RELEASE:
            begin
                if (!servo_on) state_next = svsq_pkg::ST_ENGAGE;
                else if (at_rel) state_next = svsq_pkg::ST_RUN;
            end
            svsq_pkg::ST_RUN: if (!servo_on) state_next = svsq_pkg::ST_ENGAGE;
            svsq_pkg::ST_ENGAGE: if (at_eng) state_next = svsq_pkg::ST_STANDBY;
            default: state_next = svsq_pkg::ST_IDLE;
        endcase
        if (!power_good) state_next = svsq_pkg::ST_IDLE;
    end

    // State and millisecond delay counter, cleared on every state change.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            state_reg <= svsq_pkg::ST_IDLE;
            dly_reg <= 9'h000;
        end
        else
        begin
            state_reg <= state_next;
            dly_reg <= (state_next != state_reg) ? 9'h000 : dly_reg + {8'h00, tick};
        end
    end

    // Status display selection.
    wire logic blink_fast = tk.ms_count[`SVSQ_BLINK_FAST_BIT];
    wire logic blink_slow = tk.ms_count[`SVSQ_BLINK_SLOW_BIT];
    wire logic servo_phase = (state_reg >= svsq_pkg::ST_RELEASE);
    wire logic setup_done = (state_reg >= svsq_pkg::ST_SETUP);
    wire logic led_next = alarm ? 1'b1 :
        (servo_phase || warn_any) ? blink_slow :
        (state_reg != svsq_pkg::ST_IDLE) ? blink_fast : 1'b0;
    wire logic [3:0] code_next = servo_phase ? `SVSQ_CODE_SERVO :
        setup_done ? `SVSQ_CODE_SETUP :
        (state_reg != svsq_pkg::ST_IDLE) ? `SVSQ_CODE_MAIN : `SVSQ_CODE_READY;

    // Registered outputs and display.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            outs_reg <= '0;
            led_reg <= 1'b0;
            code_reg <= `SVSQ_CODE_READY;
            ready_reg <= 1'b0;
        end
        else
        begin
            outs_reg <= outs_of(state_reg, ctrl_db_reg);
            led_reg <= led_next;
            code_reg <= code_next;
            ready_reg <= 1'b1;
        end
    end

    // APB decode: zero-wait slave, error on unmapped offsets.
    wire logic setup_ph = PSEL_I && !PENABLE_I;
    wire logic access = PSEL_I && PENABLE_I;
    wire logic hit_ctrl = (PADDR_I == `SVSQ_OFF_CTRL);
    wire logic hit_status = (PADDR_I == `SVSQ_OFF_STATUS);
    wire logic hit_istat = (PADDR_I == `SVSQ_OFF_IRQ_STAT);
    wire logic hit_imask = (PADDR_I == `SVSQ_OFF_IRQ_MASK);
    wire logic mapped = hit_ctrl || hit_status || hit_istat || hit_imask;
    wire logic wr = access && PWRITE_I;
    wire logic rd_istat = access && !PWRITE_I && hit_istat;
    logic [31:0] rd_mux;
    always_comb
    begin
        if (hit_ctrl) rd_mux = {31'h00000000, ctrl_db_reg};
        else if (hit_status) rd_mux = {19'h00000, led_reg, code_reg, 4'h0, state_reg};
        else if (hit_istat) rd_mux = {28'h0000000, irq_stat_reg};
        else if (hit_imask) rd_mux = {28'h0000000, irq_mask_reg};
        else rd_mux = 32'h00000000;
    end

    // Sequencer events; an event in the clearing read's cycle survives it.
    logic [3:0] ev;
    always_comb
    begin
        ev = 4'h0;
        ev[`SVSQ_EV_STANDBY] = (state_reg == svsq_pkg::ST_DB_WAIT) && at_db && power_good;
        ev[`SVSQ_EV_RUN] = (state_reg == svsq_pkg::ST_RELEASE) && (state_next == svsq_pkg::ST_RUN);
        ev[`SVSQ_EV_STOPPED] = (state_reg == svsq_pkg::ST_ENGAGE) && at_eng && power_good;
        ev[`SVSQ_EV_ALARM] = alarm && !alarm_d_reg;
    end

    // Register writes, read data capture and sticky status.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            ctrl_db_reg <= `SVSQ_CTRL_RESET;
            irq_mask_reg <= `SVSQ_MASK_RESET;
            irq_stat_reg <= 4'h0;
            alarm_d_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            if (wr && hit_ctrl) ctrl_db_reg <= PWDATA_I[`SVSQ_CTRL_DB_BIT];
            if (wr && hit_imask) irq_mask_reg <= PWDATA_I[3:0];
            // A read clears only the bits it returned; later events stay pending.
            irq_stat_reg <= (rd_istat ? irq_stat_reg & ~prdata_reg[3:0] : irq_stat_reg) | ev;
            alarm_d_reg <= alarm;
            if (setup_ph) prdata_reg <= rd_mux;
        end
    end

    // Port drive.
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && !mapped;
    assign AMP_READY_O = ready_reg;
    assign POWER_ON_O = outs_reg.power_on;
    assign SETUP_COMPLETE_O = outs_reg.setup_first;
    assign OPERATION_SETUP_COMPLETE_SECOND_O = outs_reg.setup_second;
    assign DYN_BRAKE_O = outs_reg.dyn_brake;
    assign HOLD_BRAKE_RELEASE_O = outs_reg.hold_release;
    assign CMD_PERMIT_O = outs_reg.cmd_permit;
    assign MOTOR_EXCITE_O = outs_reg.motor_excite;
    assign FRONT_STATUS_LED_O = led_reg;
    assign STATUS_CODE_O = code_reg;
    assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

    // Checks on the sequencer and display.
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence servo_dropped;
        (state_reg == svsq_pkg::ST_RUN) && !servo_on && power_good;
    endsequence
    sequence safe_stop;
        ##1 (state_reg == svsq_pkg::ST_ENGAGE) ##1 (!CMD_PERMIT_O && !HOLD_BRAKE_RELEASE_O);
    endsequence
    idle_display_a: assert property ((state_reg == svsq_pkg::ST_IDLE)
        && !alarm && !warn_any
        |=> (STATUS_CODE_O == `SVSQ_CODE_READY) && !FRONT_STATUS_LED_O)
        else $error("idle display not dark with code 0");
    main_code_a: assert property ((state_reg == svsq_pkg::ST_PWR_WAIT)
        |=> STATUS_CODE_O == `SVSQ_CODE_MAIN)
        else $error("status code not 2 before setup complete");
    setup_code_a: assert property ((state_reg == svsq_pkg::ST_STANDBY)
        && !alarm && !warn_any |=> (STATUS_CODE_O == `SVSQ_CODE_SETUP)
        && (FRONT_STATUS_LED_O == $past(tk.ms_count[`SVSQ_BLINK_FAST_BIT])))
        else $error("setup display wrong");
    servo_code_a: assert property ((state_reg == svsq_pkg::ST_RUN) && !alarm
        |=> (STATUS_CODE_O == `SVSQ_CODE_SERVO)
        && (FRONT_STATUS_LED_O == $past(tk.ms_count[`SVSQ_BLINK_SLOW_BIT])))
        else $error("servo-on display wrong");
    alarm_led_a: assert property (alarm |=> FRONT_STATUS_LED_O)
        else $error("alarm did not light the LED");
    power_delay_a: assert property ((state_reg == svsq_pkg::ST_PWR_WAIT) ##1
        (state_reg == svsq_pkg::ST_POWERED) |-> $past(dly_reg, 2) == `SVSQ_PWR_ON_MS)
        else $error("power-on delay not 100 ms");
    setup_after_a: assert property ($rose(SETUP_COMPLETE_O) |-> POWER_ON_O && $past(POWER_ON_O))
        else $error("setup complete before power-on");
    db_wait_a: assert property ((state_reg == svsq_pkg::ST_DB_WAIT) ##1
        (state_reg == svsq_pkg::ST_STANDBY) |-> $past(dly_reg) == `SVSQ_DB_WAIT_MS)
        else $error("servo-on accepted before relay wait");
    release_delay_a: assert property ($rose(state_reg == svsq_pkg::ST_RUN)
        |-> $past(dly_reg) == rel_ms ##1 (MOTOR_EXCITE_O && !DYN_BRAKE_O))
        else $error("brake released at wrong time");
    servo_off_a: assert property (servo_dropped |-> safe_stop)
        else $error("servo-off did not stop commands and hold brake");
    engage_delay_a: assert property ((state_reg == svsq_pkg::ST_ENGAGE)
        && power_good && at_eng
        |-> ##2 (!MOTOR_EXCITE_O && (DYN_BRAKE_O == ctrl_db_reg)))
        else $error("de-excitation not after 300 ms");
    no_db_a: assert property (!ctrl_db_reg ##1 !ctrl_db_reg |-> !DYN_BRAKE_O)
        else $error("dynamic brake driven without circuit");
    pwr_loss_a: assert property ((state_reg != svsq_pkg::ST_IDLE) && !power_good
        |=> state_reg == svsq_pkg::ST_IDLE)
        else $error("sequence kept running without power");
    early_servo_a: assert property ((state_reg == svsq_pkg::ST_DB_WAIT)
        |=> state_reg != svsq_pkg::ST_RELEASE)
        else $error("servo-on acted during relay wait");
    permit_brake_a: assert property (CMD_PERMIT_O
        |-> HOLD_BRAKE_RELEASE_O && MOTOR_EXCITE_O && !DYN_BRAKE_O)
        else $error("commands permitted with brake held");
    warn_blink_a: assert property (warn_any && !alarm
        |=> FRONT_STATUS_LED_O == $past(tk.ms_count[`SVSQ_BLINK_SLOW_BIT]))
        else $error("warning blink not at slow rate");
endmodule

// ===== svsq_map.svh
// Register offsets, field positions, reset values and timing figures of the sequencer.
`ifndef SVSQ_MAP_SVH
`define SVSQ_MAP_SVH
`define SVSQ_CLK_NS 50
`define SVSQ_MS_NS 1000000
`define SVSQ_OFF_CTRL 12'h000
`define SVSQ_OFF_STATUS 12'h004
`define SVSQ_OFF_IRQ_STAT 12'h008
`define SVSQ_OFF_IRQ_MASK 12'h00C
`define SVSQ_CTRL_DB_BIT 0
`define SVSQ_CTRL_RESET 1'h1
`define SVSQ_MASK_RESET 4'h0
`define SVSQ_PWR_ON_MS 9'h064
`define SVSQ_DB_WAIT_MS 9'h064
`define SVSQ_BRK_REL_MS 9'h12C
`define SVSQ_BRK_EXTRA_MS 9'h01C
`define SVSQ_BRK_ENG_MS 9'h12C
`define SVSQ_BLINK_FAST_BIT 7
`define SVSQ_BLINK_SLOW_BIT 9
`define SVSQ_CODE_READY 4'h0
`define SVSQ_CODE_MAIN 4'h2
`define SVSQ_CODE_SETUP 4'h4
`define SVSQ_CODE_SERVO 4'h8
`define SVSQ_EV_STANDBY 0
`define SVSQ_EV_RUN 1
`define SVSQ_EV_STOPPED 2
`define SVSQ_EV_ALARM 3
`endif

// ===== svsq_pkg.sv
// Types shared by the power sequencer modules.
package svsq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PWR_WAIT = 4'h1,
        ST_POWERED = 4'h2,
        ST_SETUP = 4'h3,
        ST_DB_WAIT = 4'h4,
        ST_STANDBY = 4'h5,
        ST_RELEASE = 4'h6,
        ST_RUN = 4'h7,
        ST_ENGAGE = 4'h8
    } svsq_state_t;
    typedef struct packed {
        logic power_on;
        logic setup_first;
        logic setup_second;
        logic dyn_brake;
        logic hold_release;
        logic cmd_permit;
        logic motor_excite;
    } svsq_outs_t;
endpackage

// ===== svsq_tick_if.sv
// Millisecond time base carried from the tick generator to the sequencer.
interface svsq_tick_if;
    logic ms_tick;
    logic [9:0] ms_count;
    modport src (output ms_tick, output ms_count);
    modport dst (input ms_tick, input ms_count);
endinterface

// ===== svsq_tick.sv
// Free-running millisecond tick and millisecond counter.
module svsq_tick #(
    parameter int CYCLES_PER_MS = 20000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    svsq_tick_if.src tb
);
    logic [15:0] cyc_reg;
    logic [9:0] ms_reg;
    logic tick_reg;
    wire logic wrap = (cyc_reg == 16'(CYCLES_PER_MS - 1));

    // Prescaler wraps once per millisecond and bumps the millisecond counter.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cyc_reg <= 16'h0000;
            ms_reg <= 10'h000;
            tick_reg <= 1'b0;
        end
        else
        begin
            cyc_reg <= wrap ? 16'h0000 : cyc_reg + 16'h0001;
            ms_reg <= wrap ? ms_reg + 10'h001 : ms_reg;
            tick_reg <= wrap;
        end
    end

    assign tb.ms_tick = tick_reg;
    assign tb.ms_count = ms_reg;
endmodule

// ===== svsq_host.sv
// Host controller model that drives main supply, power-on enable and servo-on.
module svsq_host (
    // Clock.
    input wire logic clk_i,
    // Requests from the bench.
    input wire logic want_power_i,
    input wire logic want_servo_i,
    // Lines into the amplifier.
    output logic main_ok_o,
    output logic enable_o,
    output logic servo_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int power_ups;
    // Power goes up only within the allowed cycle count and drops only with servo off.
    always @(posedge clk_i)
    begin
        if (want_power_i && !enable_o && power_ups < 5)
        begin
            main_ok_o <= 1'b1;
            enable_o <= 1'b1;
            power_ups <= power_ups + 1;
        end
        else if (!want_power_i && !servo_o)
        begin
            main_ok_o <= 1'b0;
            enable_o <= 1'b0;
        end
        servo_o <= want_servo_i & enable_o;
    end
    // Everything starts switched off.
    initial
    begin
        power_ups = 0;
        main_ok_o = 1'b0;
        enable_o = 1'b0;
        servo_o = 1'b0;
    end
endmodule

// ===== svsq_top_tb.sv
// Self-checking bench for the servo power sequencer.
`include "svsq_map.svh"
module svsq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPM = 20;
    localparam int PO = 0, SU = 1, S2 = 2, DB = 3, HB = 4, PM = 5, EX = 6, LD = 7, IQ = 8, RD = 9;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, main_ok, enable, servo;
    logic want_pwr = 1'b0;
    logic want_srv = 1'b0;
    logic alarm = 1'b0;
    logic [6:0] warn = 7'h00;
    logic [3:0] code;
    wire [9:0] obs;
    int error_cnt = 0;
    int tests_run = 0;
    int c, h, e;
    // The clock toggles every half period of 25 ns.
    always #25 clk = ~clk;
    svsq_host u_host (.clk_i(clk), .want_power_i(want_pwr), .want_servo_i(want_srv),
        .main_ok_o(main_ok), .enable_o(enable), .servo_o(servo));
    svsq_top #(.CYCLES_PER_MS(CPM)) u_dut (.SYS_CLK_I(clk), .RESET_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .MAIN_POWER_OK_I(main_ok), .POWER_ENABLE_I(enable), .SERVO_ON_I(servo),
        .ALARM_I(alarm), .WARNING_I(warn), .AMP_READY_O(obs[RD]), .POWER_ON_O(obs[PO]),
        .SETUP_COMPLETE_O(obs[SU]), .OPERATION_SETUP_COMPLETE_SECOND_O(obs[S2]),
        .DYN_BRAKE_O(obs[DB]), .HOLD_BRAKE_RELEASE_O(obs[HB]), .CMD_PERMIT_O(obs[PM]),
        .MOTOR_EXCITE_O(obs[EX]), .FRONT_STATUS_LED_O(obs[LD]), .STATUS_CODE_O(code),
        .IRQ_O(obs[IQ]));
    // Value and range comparisons.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic bit_is(input int i, input logic v);
        chk({31'h0, obs[i]}, {31'h0, v});
    endtask
    // One APB transfer, held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic err;
        apb(1'b1, a, d, q, err);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic err;
        apb(1'b0, a, 32'h0, q, err);
        chk(q, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask
    // Waits at falling edges until an output reaches a level; returns the cycles spent.
    task automatic wait_bit(input int i, input logic v, output int n);
        n = 0;
        while (obs[i] !== v && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        if (obs[i] !== v)
            error_cnt++;
    endtask
    // Counts status lamp transitions over a number of cycles.
    task automatic led_edges(input int cyc, output int n);
        logic prev;
        n = 0;
        prev = obs[LD];
        repeat (cyc)
        begin
            @(negedge clk);
            if (obs[LD] !== prev)
                n++;
            prev = obs[LD];
        end
    endtask
    task automatic t_reset();
        repeat (2) @(negedge clk);
        bit_is(RD, 1'b1);
        bit_is(LD, 1'b0);
        chk({28'h0, code}, 32'h0);
        rd(`SVSQ_OFF_CTRL, 32'h1, 1'b0);
        rd(`SVSQ_OFF_IRQ_MASK, 32'h0, 1'b0);
        rd(`SVSQ_OFF_STATUS, 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
    endtask
    task automatic t_power_up();
        want_pwr <= 1'b1;
        wait_bit(PO, 1'b1, c);
        chk_in(c, 100 * CPM, 101 * CPM + 8);
        bit_is(SU, 1'b0);
        chk({28'h0, code}, 32'h2);
        wait_bit(SU, 1'b1, c);
        chk_in(c, 1, CPM + 2);
        wait_bit(S2, 1'b1, c);
        @(posedge clk);
        want_srv <= 1'b1;
        chk({28'h0, code}, 32'h4);
    endtask
    task automatic t_servo_on();
        wait_bit(EX, 1'b1, c);
        chk_in(c, 100 * CPM - 2, 101 * CPM + 4);
        bit_is(DB, 1'b0);
        bit_is(HB, 1'b0);
        wait_bit(PM, 1'b1, c);
        chk_in(c, 328 * CPM - 2, 329 * CPM + 4);
        bit_is(HB, 1'b1);
        chk({28'h0, code}, 32'h8);
        bit_is(IQ, 1'b0);
        led_edges(256 * CPM, e);
        chk_in(e, 0, 1);
        wr(`SVSQ_OFF_IRQ_MASK, 32'hF);
        @(negedge clk);
        bit_is(IQ, 1'b1);
        rd(`SVSQ_OFF_IRQ_STAT, 32'h3, 1'b0);
        repeat (2) @(negedge clk);
        bit_is(IQ, 1'b0);
    endtask
    task automatic t_servo_off();
        want_srv <= 1'b0;
        wait_bit(PM, 1'b0, c);
        chk_in(c, 0, 8);
        bit_is(HB, 1'b0);
        bit_is(EX, 1'b1);
        wait_bit(EX, 1'b0, c);
        chk_in(c, 300 * CPM - 2, 301 * CPM + 4);
        bit_is(DB, 1'b1);
        wr(`SVSQ_OFF_CTRL, 32'h0);
        repeat (3) @(negedge clk);
        bit_is(DB, 1'b0);
        wr(`SVSQ_OFF_CTRL, 32'h1);
        repeat (3) @(negedge clk);
        bit_is(DB, 1'b1);
        rd(`SVSQ_OFF_IRQ_STAT, 32'h4, 1'b0);
        wr(`SVSQ_OFF_IRQ_MASK, 32'h8);
    endtask
    task automatic t_blink();
        chk({28'h0, code}, 32'h4);
        wait_bit(LD, 1'b0, c);
        wait_bit(LD, 1'b1, c);
        wait_bit(LD, 1'b0, h);
        chk_in(h, 128 * CPM - 1, 128 * CPM + 1);
        wait_bit(LD, 1'b1, h);
        chk_in(h, 128 * CPM - 1, 128 * CPM + 1);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            warn <= 7'h01 << i;
            repeat (6) @(negedge clk);
            led_edges(256 * CPM, e);
            chk_in(e, 0, 1);
        end
        @(posedge clk);
        warn <= 7'h00;
    endtask
    task automatic t_alarm();
        alarm <= 1'b1;
        repeat (8) @(negedge clk);
        bit_is(IQ, 1'b1);
        led_edges(140 * CPM, e);
        chk_in(e, 0, 0);
        bit_is(LD, 1'b1);
        rd(`SVSQ_OFF_IRQ_STAT, 32'h8, 1'b0);
        alarm <= 1'b0;
        want_pwr <= 1'b0;
        wait_bit(PO, 1'b0, c);
        chk_in(c, 1, 10);
        chk({28'h0, code}, 32'h0);
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence after a reset of twelve cycles.
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_power_up();
        t_servo_on();
        t_servo_off();
        t_blink();
        t_alarm();
        conclude();
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule
